// ### shared/sgp_pkg.sv
/*
  Constants for the six-pin general purpose I/O block: register offsets,
  field positions, reset values and timing counts.
  Assumes a 12-bit byte address on the register port and a 200 MHz clock.
*/
package sgp_pkg;

  localparam int unsigned NUM_PINS              = 6;
  localparam int unsigned ADDR_W                = 12;
  localparam int unsigned DATA_W                = 32;

  // register byte addresses
  localparam logic [11:0] PIN_CONFIG_OFS        = 12'h1E0;
  localparam logic [11:0] PIN_DATA_DIRECTION_OFS = 12'h1E4;
  localparam logic [11:0] PIN_IRQ_STATUS_ENABLE_OFS = 12'h1E8;

  // pin_config_reg fields
  localparam int unsigned PIN_DRIVER_TYPE_LSB   = 0;
  localparam int unsigned PIN_TRIGGER_LEVEL_LSB = 16;

  // pin_data_direction_reg fields
  localparam int unsigned PIN_DATA_BITS_LSB     = 0;
  localparam int unsigned PIN_DIRECTION_LSB     = 16;

  // pin_irq_status_enable_reg fields
  localparam int unsigned PIN_IRQ_STATUS_LSB    = 0;
  localparam int unsigned PIN_IRQ_ENABLE_LSB    = 16;

  // reset values of every field
  localparam logic [5:0]  PIN_FIELD_RESET       = 6'h00;
  // pads idle high through their pull-ups; the pin synchroniser starts there
  localparam logic [5:0]  PIN_SYNC_RESET        = 6'h3F;

  // field encodings
  localparam logic        DRIVER_OPEN_DRAIN     = 1'b0;
  localparam logic        DRIVER_PUSH_PULL      = 1'b1;
  localparam logic        DIRECTION_INPUT       = 1'b0;
  localparam logic        DIRECTION_OUTPUT      = 1'b1;

  // timing
  localparam int unsigned CLK_PERIOD_PS         = 5000;
  localparam int unsigned TRIGGER_MIN_NS        = 40;
  localparam int unsigned TRIGGER_MIN_CYCLES    =
    (TRIGGER_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SYNC_STAGES           = 3;

endpackage : sgp_pkg

// ### core/sgp_gpio.sv
/*
  Six-pin general purpose I/O block with level-triggered per-pin
  interrupt status, feeding one combined event into the system
  interrupt controller.
  Assumes: a plain register port (one-cycle strobes, read data one cycle
  later), the pad ring resolves pin level from o_pin and o_pin_oe, and the
  LED function with its select bits lives outside this block.
*/
`timescale 1ns/1ps
`default_nettype none

module sgp_gpio (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic [11:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic [5:0]  i_pin,
  output logic      [5:0]  o_pin,
  output logic      [5:0]  o_pin_oe,
  input  wire logic [5:0]  i_led_select_bits,
  input  wire logic [5:0]  i_led_out,
  input  wire logic [5:0]  i_led_oe,
  input  wire logic        i_gpio_event_enable,
  output logic             o_gpio_event,
  output logic             o_irq_request
);

  // places a six-bit field into a 32-bit word, other bits zero
  function automatic logic [31:0] sgp_place6(input logic [5:0] value, input int unsigned lsb);
    logic [31:0] word;
    word = 32'h0000_0000;
    word[lsb +: 6] = value;
    return word;
  endfunction : sgp_place6

  // takes a six-bit field out of a 32-bit word
  function automatic logic [5:0] sgp_take6(input logic [31:0] word, input int unsigned lsb);
    return word[lsb +: 6];
  endfunction : sgp_take6

  // register state
  logic [5:0]  trigger_level_reg;
  logic [5:0]  driver_type_reg;
  logic [5:0]  direction_reg;
  logic [5:0]  data_bits_reg;
  logic [5:0]  irq_enable_reg;
  logic [5:0]  irq_status_reg;
  logic [5:0]  irq_status_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [5:0]  pin_out_reg;
  logic [5:0]  pin_out_next;
  logic [5:0]  pin_oe_reg;
  logic [5:0]  pin_oe_next;
  logic        event_reg;
  logic        event_next;
  logic        irq_reg;
  logic        irq_next;

  // pin synchroniser and agreement filter
  logic [5:0]  sync1_reg;
  logic [5:0]  sync2_reg;
  logic [5:0]  sync3_reg;
  logic [5:0]  pin_level_reg;
  logic [5:0]  pin_level_next;

  // decode
  wire         sel_config  = (i_addr == sgp_pkg::PIN_CONFIG_OFS);
  wire         sel_datadir = (i_addr == sgp_pkg::PIN_DATA_DIRECTION_OFS);
  wire         sel_irq     = (i_addr == sgp_pkg::PIN_IRQ_STATUS_ENABLE_OFS);
  wire         wr_config   = i_wr & sel_config;
  wire         wr_datadir  = i_wr & sel_datadir;
  wire         wr_irq      = i_wr & sel_irq;

  wire  [5:0]  gpio_mode   = ~i_led_select_bits;
  wire  [5:0]  is_output   = direction_reg & gpio_mode;
  wire  [5:0]  push_pull   = is_output & driver_type_reg;
  wire  [5:0]  open_drain  = is_output & ~driver_type_reg;

  // trigger when the filtered level equals the configured level
  wire  [5:0]  trigger_hit = ~(pin_level_reg ^ trigger_level_reg) & gpio_mode;

  wire  [5:0]  status_clear = wr_irq ? sgp_take6(i_wdata, sgp_pkg::PIN_IRQ_STATUS_LSB)
                                     : 6'h00;

  wire  [5:0]  data_read   = (direction_reg & data_bits_reg)
                           | (~direction_reg & pin_level_reg);

  wire  [31:0] word_config  = sgp_place6(trigger_level_reg, sgp_pkg::PIN_TRIGGER_LEVEL_LSB)
                            | sgp_place6(driver_type_reg, sgp_pkg::PIN_DRIVER_TYPE_LSB);
  wire  [31:0] word_datadir = sgp_place6(direction_reg, sgp_pkg::PIN_DIRECTION_LSB)
                            | sgp_place6(data_read, sgp_pkg::PIN_DATA_BITS_LSB);
  wire  [31:0] word_irq     = sgp_place6(irq_enable_reg, sgp_pkg::PIN_IRQ_ENABLE_LSB)
                            | sgp_place6(irq_status_reg, sgp_pkg::PIN_IRQ_STATUS_LSB);

  // a change is accepted only once stages two and three agree
  always_comb begin
    pin_level_next = pin_level_reg;
    for (int i = 0; i < sgp_pkg::NUM_PINS; i++) begin
      if (sync2_reg[i] == sync3_reg[i]) begin
        pin_level_next[i] = sync3_reg[i];
      end
    end
  end

  // set wins over a clear in the same cycle, and re-sets while the level stays
  always_comb begin
    irq_status_next = (irq_status_reg & ~status_clear) | trigger_hit;
  end

  always_comb begin
    event_next = |(irq_status_reg & irq_enable_reg);
    irq_next   = event_next & i_gpio_event_enable;
  end

  always_comb begin
    if (!i_rd) begin
      rdata_next = 32'h0000_0000;
    end else if (sel_config) begin
      rdata_next = word_config;
    end else if (sel_datadir) begin
      rdata_next = word_datadir;
    end else if (sel_irq) begin
      rdata_next = word_irq;
    end else begin
      rdata_next = 32'h0000_0000;
    end
  end

  // pin drive: LED pins pass through, outputs as configured, inputs undriven
  always_comb begin
    pin_out_next = (push_pull & data_bits_reg)
                 | (i_led_select_bits & i_led_out);
    pin_oe_next  = push_pull
                 | (open_drain & ~data_bits_reg)
                 | (i_led_select_bits & i_led_oe);
  end

  // the first stage feeds only the second; a zero reset would fake a low-level trigger
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sync1_reg     <= sgp_pkg::PIN_SYNC_RESET;
      sync2_reg     <= sgp_pkg::PIN_SYNC_RESET;
      sync3_reg     <= sgp_pkg::PIN_SYNC_RESET;
      pin_level_reg <= sgp_pkg::PIN_SYNC_RESET;
    end else begin
      sync1_reg     <= i_pin;
      sync2_reg     <= sync1_reg;
      sync3_reg     <= sync2_reg;
      pin_level_reg <= pin_level_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      trigger_level_reg <= sgp_pkg::PIN_FIELD_RESET;
      driver_type_reg   <= sgp_pkg::PIN_FIELD_RESET;
    end else if (wr_config) begin
      trigger_level_reg <= sgp_take6(i_wdata, sgp_pkg::PIN_TRIGGER_LEVEL_LSB);
      driver_type_reg   <= sgp_take6(i_wdata, sgp_pkg::PIN_DRIVER_TYPE_LSB);
    end
  end

  // data bits keep the written value even for inputs, ready for a direction change
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      direction_reg <= sgp_pkg::PIN_FIELD_RESET;
      data_bits_reg <= sgp_pkg::PIN_FIELD_RESET;
    end else if (wr_datadir) begin
      direction_reg <= sgp_take6(i_wdata, sgp_pkg::PIN_DIRECTION_LSB);
      data_bits_reg <= sgp_take6(i_wdata, sgp_pkg::PIN_DATA_BITS_LSB);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      irq_enable_reg <= sgp_pkg::PIN_FIELD_RESET;
    end else if (wr_irq) begin
      irq_enable_reg <= sgp_take6(i_wdata, sgp_pkg::PIN_IRQ_ENABLE_LSB);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      irq_status_reg <= sgp_pkg::PIN_FIELD_RESET;
      event_reg      <= 1'b0;
      irq_reg        <= 1'b0;
      rdata_reg      <= 32'h0000_0000;
      pin_out_reg    <= 6'h00;
      pin_oe_reg     <= 6'h00;
    end else begin
      irq_status_reg <= irq_status_next;
      event_reg      <= event_next;
      irq_reg        <= irq_next;
      rdata_reg      <= rdata_next;
      pin_out_reg    <= pin_out_next;
      pin_oe_reg     <= pin_oe_next;
    end
  end

  assign o_rdata       = rdata_reg;
  assign o_pin         = pin_out_reg;
  assign o_pin_oe      = pin_oe_reg;
  assign o_gpio_event  = event_reg;
  assign o_irq_request = irq_reg;

  // checks
  localparam int RECOG_MAX = 6;

  logic [3:0] hold_cnt_reg;
  wire        raw_hit0 = (i_pin[0] == trigger_level_reg[0]) & ~i_led_select_bits[0];

  always_ff @(posedge i_clk) begin
    if (i_reset || !raw_hit0 || wr_config) begin
      hold_cnt_reg <= 4'h0;
    end else if (hold_cnt_reg != 4'hF) begin
      hold_cnt_reg <= hold_cnt_reg + 4'h1;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  property p_status_set;
    ##1 ((irq_status_reg & $past(trigger_hit)) == $past(trigger_hit));
  endproperty
  a_status_set: assert property (p_status_set) else $error("status missed a trigger");

  property p_status_clear;
    wr_irq && (status_clear & ~trigger_hit & irq_status_reg) != 6'h00
      |=> (irq_status_reg & $past(status_clear & ~trigger_hit)) == 6'h00;
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status not cleared");

  property p_trigger_level;
    (pin_level_reg[0] == trigger_level_reg[0]) && !i_led_select_bits[0] |=> irq_status_reg[0];
  endproperty
  a_trigger_level: assert property (p_trigger_level) else $error("level trigger ignored");

  property p_open_drain;
    ##1 ((o_pin_oe & $past(open_drain)) == ($past(open_drain) & ~$past(data_bits_reg)))
        && ((o_pin & $past(open_drain)) == 6'h00);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open-drain drive wrong");

  property p_push_pull;
    ##1 ((o_pin & $past(push_pull)) == ($past(push_pull) & $past(data_bits_reg)))
        && ((o_pin_oe & $past(push_pull)) == $past(push_pull));
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("push-pull drive wrong");

  property p_input_undriven;
    ##1 ((o_pin_oe & $past(~direction_reg & gpio_mode)) == 6'h00);
  endproperty
  a_input_undriven: assert property (p_input_undriven) else $error("input pin driven");

  property p_led_pass;
    ##1 ((o_pin & $past(i_led_select_bits)) == $past(i_led_select_bits & i_led_out));
  endproperty
  a_led_pass: assert property (p_led_pass) else $error("led pin not passed through");

  property p_data_read;
    i_rd && sel_datadir |=> o_rdata[5:0] == $past(data_read)
                            && o_rdata[21:16] == $past(direction_reg);
  endproperty
  a_data_read: assert property (p_data_read) else $error("data read wrong");

  property p_event;
    ##1 (o_gpio_event == |($past(irq_status_reg) & $past(irq_enable_reg)));
  endproperty
  a_event: assert property (p_event) else $error("combined event wrong");

  property p_irq_gate;
    o_irq_request |-> o_gpio_event && $past(i_gpio_event_enable);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without system enable");

  property p_recognise;
    hold_cnt_reg == 4'(sgp_pkg::TRIGGER_MIN_CYCLES) |-> ##[0:RECOG_MAX] irq_status_reg[0];
  endproperty
  a_recognise: assert property (p_recognise) else $error("held trigger not seen");

  property p_sync_delay;
    (sync2_reg == sync3_reg) |=> pin_level_reg == $past(sync3_reg);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync chain broken");

  c_irq_raised:   cover property (!o_irq_request ##1 o_irq_request);
  c_clear_retry:  cover property (wr_irq && (status_clear & trigger_hit) != 6'h00);
  c_open_drain:   cover property (open_drain != 6'h00 ##1 o_pin_oe != 6'h00);
  c_input_read:   cover property (i_rd && sel_datadir && direction_reg == 6'h00);

endmodule : sgp_gpio

`default_nettype wire

// ### verification/sgp_board.sv
/*
  Board-side model of the six general purpose pins.
  Assumes each pin carries a pull-up and may be driven by an external source that
  the bench only enables while the device leaves the pin undriven.
*/
`timescale 1ns/1ps
`default_nettype none
module sgp_board (
  input  wire logic [5:0] i_pin_out,
  input  wire logic [5:0] i_pin_oe,
  input  wire logic [5:0] i_ext_val,
  input  wire logic [5:0] i_ext_en,
  output logic      [5:0] o_level
);
  // device drive wins so a bench slip shows as a wrong level, not an unknown;
  // an undriven pin floats up through its pull-up
  assign o_level = (i_pin_oe & i_pin_out) |
                   (~i_pin_oe & i_ext_en & i_ext_val) |
                   (~i_pin_oe & ~i_ext_en);
endmodule : sgp_board
`default_nettype wire

// ### verification/test_sgp_gpio.sv
/*
  Self-checking bench for the general purpose I/O block: register readback,
  pin drive, level-triggered status, combined event and interrupt request.
  Assumes the board model resolves the pin wires; stimulus comes from a fixed LFSR.
*/
`timescale 1ns/1ps
`default_nettype none
module test_sgp_gpio;
  logic        i_clk;
  logic        i_reset;
  logic [11:0] i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rdata;
  logic [5:0]  o_pin;
  logic [5:0]  o_pin_oe;
  logic [5:0]  i_led_select_bits;
  logic [5:0]  i_led_out;
  logic [5:0]  i_led_oe;
  logic        i_gpio_event_enable;
  logic        o_gpio_event;
  logic        o_irq_request;
  logic [5:0]  ext_val;
  logic [5:0]  ext_en;
  logic [5:0]  pin_level;
  logic [31:0] lfsr;
  logic [31:0] rd_val;
  logic [31:0] cfg;
  logic [31:0] dd;
  logic [31:0] rnd;
  logic [11:0] drv;
  logic [5:0]  en;
  logic [5:0]  lv;
  logic [5:0]  st;
  logic [31:0] msk;
  int          err_count;
  int          checks;

  sgp_gpio sgp_gpio_i (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin(pin_level), .o_pin(o_pin),
    .o_pin_oe(o_pin_oe), .i_led_select_bits(i_led_select_bits), .i_led_out(i_led_out),
    .i_led_oe(i_led_oe), .i_gpio_event_enable(i_gpio_event_enable),
    .o_gpio_event(o_gpio_event), .o_irq_request(o_irq_request));
  sgp_board sgp_board_i (.i_pin_out(o_pin), .i_pin_oe(o_pin_oe), .i_ext_val(ext_val),
    .i_ext_en(ext_en), .o_level(pin_level));

  function automatic logic [31:0] next_lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_lfsr

  // {oe, out} per pin; an open-drain pin only drives while its data bit is 0
  function automatic logic [11:0] drive_exp(input logic [5:0] dir, data, pp, led, lo, loe);
    logic [11:0] r;
    for (int i = 0; i < 6; i++) begin
      r[i + 6] = led[i] ? loe[i] : dir[i] & (pp[i] | ~data[i]);
      r[i]     = led[i] ? lo[i] : data[i];
    end
    return r;
  endfunction : drive_exp

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
  endtask : idle

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe, so sample mid-cycle
  task automatic rd(input logic [11:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    @(negedge i_clk);
    rd_val = o_rdata;
  endtask : rd

  task automatic finish_test;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // watchdog: the whole sequence is far shorter than this bound
  initial begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    finish_test();
  end

  initial begin
    err_count = 0;
    checks = 0;
    lfsr = 32'h28A0;
    i_reset = 1'b1;
    i_addr = 12'h000;
    i_wdata = 32'h0000_0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_led_select_bits = 6'h00;
    i_led_out = 6'h00;
    i_led_oe = 6'h00;
    i_gpio_event_enable = 1'b0;
    ext_val = 6'h00;
    ext_en = 6'h00;
    idle(6);
    i_reset <= 1'b0;
    idle(8);
    check({26'h0, o_pin_oe}, 32'h0000_0000);
    // pins float high and trigger level resets low: no status; unmapped reads zero
    rd(sgp_pkg::PIN_CONFIG_OFS);
    check(rd_val, 32'h0000_0000);
    rd(sgp_pkg::PIN_DATA_DIRECTION_OFS);
    check(rd_val, 32'h0000_003F);
    rd(sgp_pkg::PIN_IRQ_STATUS_ENABLE_OFS);
    check(rd_val, 32'h0000_0000);
    wr(12'h1EC, 32'hFFFF_FFFF);
    rd(12'h1EC);
    check(rd_val, 32'h0000_0000);
    for (int n = 0; n < 16; n++) begin
      lfsr = next_lfsr(lfsr);
      cfg = lfsr & 32'h003F_003F;
      lfsr = next_lfsr(lfsr);
      dd = lfsr & 32'h003F_003F;
      lfsr = next_lfsr(lfsr);
      rnd = lfsr;
      lfsr = next_lfsr(lfsr);
      en = lfsr[5:0];
      drv = drive_exp(dd[21:16], dd[5:0], cfg[5:0], rnd[5:0] & rnd[13:8], rnd[21:16],
                      rnd[29:24]);
      lv = (drv[11:6] & drv[5:0]) | (~drv[11:6] & lfsr[13:8]);
      @(posedge i_clk);
      i_led_select_bits   <= rnd[5:0] & rnd[13:8];
      i_led_out           <= rnd[21:16];
      i_led_oe            <= rnd[29:24];
      i_gpio_event_enable <= rnd[31];
      ext_en              <= ~drv[11:6];
      ext_val             <= lfsr[13:8];
      wr(sgp_pkg::PIN_CONFIG_OFS, cfg);
      wr(sgp_pkg::PIN_DATA_DIRECTION_OFS, dd);
      idle(8);
      check({26'h0, o_pin_oe}, {26'h0, drv[11:6]});
      check({26'h0, o_pin & drv[11:6]}, {26'h0, drv[5:0] & drv[11:6]});
      rd(sgp_pkg::PIN_CONFIG_OFS);
      check(rd_val, cfg);
      msk = ~{26'h0, rnd[5:0] & rnd[13:8]};
      rd(sgp_pkg::PIN_DATA_DIRECTION_OFS);
      check(rd_val & msk, {10'h0, dd[21:16], 10'h0, (dd[21:16] & dd[5:0]) |
            (~dd[21:16] & lv)} & msk);
      wr(sgp_pkg::PIN_IRQ_STATUS_ENABLE_OFS, {10'h0, en, 16'h003F});
      idle(3);
      st = ~(rnd[5:0] & rnd[13:8]) & ~(lv ^ cfg[21:16]);
      rd(sgp_pkg::PIN_IRQ_STATUS_ENABLE_OFS);
      check(rd_val, {10'h0, en, 10'h0, st});
      check({31'h0, o_gpio_event}, {31'h0, |(st & en)});
      check({31'h0, o_irq_request}, {31'h0, (|(st & en)) & rnd[31]});
    end
    // mid-run reset with the pins left to their pull-ups: no status may appear
    @(posedge i_clk);
    i_reset             <= 1'b1;
    i_led_select_bits   <= 6'h00;
    ext_en              <= 6'h00;
    idle(3);
    i_reset <= 1'b0;
    idle(8);
    check({26'h0, o_pin_oe}, 32'h0000_0000);
    rd(sgp_pkg::PIN_CONFIG_OFS);
    check(rd_val, 32'h0000_0000);
    rd(sgp_pkg::PIN_IRQ_STATUS_ENABLE_OFS);
    check(rd_val, 32'h0000_0000);
    rd(sgp_pkg::PIN_DATA_DIRECTION_OFS);
    check(rd_val, 32'h0000_003F);
    // a single high pulse just over the minimum width on pin 2, enables off
    @(posedge i_clk);
    i_led_select_bits   <= 6'h00;
    i_gpio_event_enable <= 1'b0;
    ext_en              <= 6'h3F;
    ext_val             <= 6'h00;
    wr(sgp_pkg::PIN_CONFIG_OFS, 32'h003F_0000);
    wr(sgp_pkg::PIN_DATA_DIRECTION_OFS, 32'h0000_0000);
    idle(8);
    wr(sgp_pkg::PIN_IRQ_STATUS_ENABLE_OFS, 32'h0000_003F);
    idle(3);
    check({31'h0, o_gpio_event}, 32'h0000_0000);
    @(posedge i_clk);
    ext_val <= 6'h04;
    idle(9);
    ext_val <= 6'h00;
    idle(8);
    rd(sgp_pkg::PIN_IRQ_STATUS_ENABLE_OFS);
    check(rd_val, 32'h0000_0004);
    check({31'h0, o_gpio_event}, 32'h0000_0000);
    wr(sgp_pkg::PIN_IRQ_STATUS_ENABLE_OFS, 32'h0004_0000);
    idle(3);
    rd(sgp_pkg::PIN_IRQ_STATUS_ENABLE_OFS);
    check(rd_val, 32'h0004_0004);
    check({31'h0, o_gpio_event}, 32'h0000_0001);
    check({31'h0, o_irq_request}, 32'h0000_0000);
    @(posedge i_clk);
    i_gpio_event_enable <= 1'b1;
    idle(3);
    check({31'h0, o_irq_request}, 32'h0000_0001);
    wr(sgp_pkg::PIN_IRQ_STATUS_ENABLE_OFS, 32'h0004_0004);
    idle(3);
    check({31'h0, o_gpio_event}, 32'h0000_0000);
    check({31'h0, o_irq_request}, 32'h0000_0000);
    finish_test();
  end
endmodule : test_sgp_gpio
`default_nettype wire
